// [include/host_port_pkg.sv]
// Shared constants and types for the encoder host port and pixel path
`default_nettype none

package host_port_pkg;

    // Port select codes
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_ADDRESS = 2'h1;
    localparam logic [1:0] SEL_SPARE   = 2'h2;
    localparam logic [1:0] SEL_TABLE   = 2'h3;

    // Component byte counter
    localparam logic [1:0] COMP_FIRST = 2'h0;
    localparam logic [1:0] COMP_LAST  = 2'h2;

    // Control register layout and reset values
    localparam int         CTRL_BYPASS_BIT = 0;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] ADDR_RESET      = 8'h00;

    // Timing
    localparam int CLK_PERIOD_PS        = 4000;
    localparam int READ_ACCESS_DELAY_NS = 54;
    localparam int PIXEL_PIPELINE_LATENCY = 44;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WRITE,
        SEQ_READ
    } seq_state_t;

endpackage

`default_nettype wire

// [design/pixel_delay_line.sv]
// Fixed-length shift register for the pixel pipeline
`timescale 1ns/1ps
`default_nettype none

module pixel_delay_line #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 43
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             srst,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage_q [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    stage_q[i] <= '0;
                end else begin
                    stage_q[i] <= (i == 0) ? din : stage_q[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    assign dout = stage_q[DEPTH-1];

endmodule // pixel_delay_line

`default_nettype wire

// [design/video_encoder_host_port_lut_access.sv]
// Host port with colour lookup table access and fixed-latency pixel path
//
// Behaviour
// - Pixel to output delay is exactly 44 clocks.
// - Half-rate clock divides master clock, phase reset.
// - One strobe pulse executes exactly one step.
// - Direction/select at fall, write data at rise.
// - Written value commits at next strobe fall.
// - Read drives bus from fall, releases at rise.
// - Control read data valid within 1 clock+54ns.
// - First table read is a dummy prefetch step.
// - Then three reads return components in order.
// - Extra fall after table reads ends sequence.
// - Select 01 is address, 11 is table data.
// - Address advances after third component byte.
// - Address read returns current address, ends writes.
// - Address write during table read ends it.
`timescale 1ns/1ps
`default_nettype none

module video_encoder_host_port_lut_access #(
    parameter int ENTRIES = 256,
    parameter int LATENCY = host_port_pkg::PIXEL_PIPELINE_LATENCY
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Host parallel port
    input  wire logic        strobe_n,
    input  wire logic        read_not_write,
    input  wire logic [1:0]  port_select,
    input  wire logic [7:0]  host_bus_in,
    output logic      [7:0]  host_bus_out,
    output logic             host_bus_oe,
    // Pixel path
    input  wire logic [7:0]  pixel_input_port,
    output logic      [23:0] video_word,
    output logic             half_rate_clock
);

    // Strobe synchroniser and edge detection
    logic strobe_s1_q;
    logic strobe_s2_q;
    logic strobe_s3_q;
    logic strobe_fall;
    logic strobe_rise;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strobe_s1_q <= 1'b1;
            strobe_s2_q <= 1'b1;
            strobe_s3_q <= 1'b1;
        end else begin
            strobe_s1_q <= strobe_n;
            strobe_s2_q <= strobe_s1_q;
            strobe_s3_q <= strobe_s2_q;
        end
    end

    assign strobe_fall = strobe_s3_q & ~strobe_s2_q;
    assign strobe_rise = ~strobe_s3_q & strobe_s2_q;

    // Step capture state
    logic                    in_step_q;
    logic                    step_rw_q;
    logic [1:0]              step_sel_q;
    logic                    pend_valid_q;
    logic [1:0]              pend_sel_q;
    logic [7:0]              pend_data_q;
    logic [7:0]              addr_q;
    logic [7:0]              addr_d;
    logic [1:0]              comp_q;
    logic [1:0]              comp_d;
    logic [7:0]              ctrl_q;
    logic [7:0]              ctrl_d;
    logic [23:0]             rdbuf_q;
    logic [23:0]             rdbuf_d;
    logic [23:0]             wbuf_q;
    logic [23:0]             wbuf_d;
    logic [7:0]              out_d;
    logic                    mem_we;
    logic [7:0]              mem_waddr;
    host_port_pkg::seq_state_t state_q;
    host_port_pkg::seq_state_t state_d;

    // Lookup table storage
    logic [23:0] table_mem [ENTRIES];

    // Pick one component byte out of an entry
    function automatic logic [7:0] comp_byte(input logic [23:0] entry, input logic [1:0] idx);
        logic [7:0] b;
        case (idx)
            2'h0:    b = entry[23:16];
            2'h1:    b = entry[15:8];
            default: b = entry[7:0];
        endcase
        return b;
    endfunction

    // Merge one component byte into an entry
    function automatic logic [23:0] put_byte(input logic [23:0] entry, input logic [1:0] idx,
                                             input logic [7:0] b);
        logic [23:0] e;
        e = entry;
        case (idx)
            2'h0:    e[23:16] = b;
            2'h1:    e[15:8]  = b;
            default: e[7:0]   = b;
        endcase
        return e;
    endfunction

    // Sequencing at each strobe fall: commit pending write, then start new step
    logic [7:0] addr_mid;
    logic [1:0] comp_mid;
    logic       new_read;
    logic       new_table_read;

    assign new_read       = read_not_write;
    assign new_table_read = read_not_write && (port_select == host_port_pkg::SEL_TABLE);

    always_comb begin
        addr_d    = addr_q;
        comp_d    = comp_q;
        ctrl_d    = ctrl_q;
        rdbuf_d   = rdbuf_q;
        wbuf_d    = wbuf_q;
        state_d   = state_q;
        out_d     = 8'h00;
        mem_we    = 1'b0;
        mem_waddr = addr_q;
        addr_mid  = addr_q;
        comp_mid  = comp_q;
        if (strobe_fall) begin
            if (pend_valid_q) begin
                case (pend_sel_q)
                    host_port_pkg::SEL_ADDRESS: begin
                        addr_d  = pend_data_q;
                        comp_d  = host_port_pkg::COMP_FIRST;
                        state_d = host_port_pkg::SEQ_IDLE;
                    end
                    host_port_pkg::SEL_TABLE: begin
                        wbuf_d  = put_byte(wbuf_q, comp_q, pend_data_q);
                        state_d = host_port_pkg::SEQ_WRITE;
                        if (comp_q == host_port_pkg::COMP_LAST) begin
                            mem_we = 1'b1;
                            addr_d = addr_q + 8'h01;
                            comp_d = host_port_pkg::COMP_FIRST;
                        end else begin
                            comp_d = comp_q + 2'h1;
                        end
                    end
                    host_port_pkg::SEL_CONTROL: begin
                        ctrl_d = pend_data_q;
                    end
                    default: begin
                    end
                endcase
            end
            addr_mid = addr_d;
            comp_mid = comp_d;
            if (new_table_read) begin
                if (state_d != host_port_pkg::SEQ_READ) begin
                    rdbuf_d = table_mem[addr_mid];
                    comp_d  = host_port_pkg::COMP_FIRST;
                    state_d = host_port_pkg::SEQ_READ;
                    out_d   = comp_byte(rdbuf_q, host_port_pkg::COMP_FIRST);
                end else begin
                    out_d = comp_byte(rdbuf_q, comp_mid);
                    if (comp_mid == host_port_pkg::COMP_LAST) begin
                        addr_d  = addr_mid + 8'h01;
                        rdbuf_d = table_mem[addr_mid + 8'h01];
                        comp_d  = host_port_pkg::COMP_FIRST;
                    end else begin
                        comp_d = comp_mid + 2'h1;
                    end
                end
            end else if (new_read) begin
                // Any register read ends a write or read sequence
                state_d = host_port_pkg::SEQ_IDLE;
                comp_d  = host_port_pkg::COMP_FIRST;
                case (port_select)
                    host_port_pkg::SEL_ADDRESS: out_d = addr_mid;
                    host_port_pkg::SEL_CONTROL: out_d = ctrl_d;
                    default:                    out_d = 8'h00;
                endcase
            end else if (state_d == host_port_pkg::SEQ_READ) begin
                state_d = host_port_pkg::SEQ_IDLE;
                comp_d  = host_port_pkg::COMP_FIRST;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            table_mem[mem_waddr] <= wbuf_d;
        end
    end

    // Step framing and pending write capture
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            in_step_q    <= 1'b0;
            step_rw_q    <= 1'b1;
            step_sel_q   <= host_port_pkg::SEL_CONTROL;
            pend_valid_q <= 1'b0;
            pend_sel_q   <= host_port_pkg::SEL_CONTROL;
            pend_data_q  <= 8'h00;
        end else if (strobe_fall) begin
            in_step_q    <= 1'b1;
            step_rw_q    <= read_not_write;
            step_sel_q   <= port_select;
            pend_valid_q <= 1'b0;
        end else if (strobe_rise && in_step_q) begin
            in_step_q <= 1'b0;
            if (!step_rw_q) begin
                pend_valid_q <= 1'b1;
                pend_sel_q   <= step_sel_q;
                pend_data_q  <= host_bus_in;
            end
        end
    end

    // Sequence state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addr_q  <= host_port_pkg::ADDR_RESET;
            comp_q  <= host_port_pkg::COMP_FIRST;
            ctrl_q  <= host_port_pkg::CTRL_RESET;
            rdbuf_q <= '0;
            wbuf_q  <= '0;
            state_q <= host_port_pkg::SEQ_IDLE;
        end else begin
            addr_q  <= addr_d;
            comp_q  <= comp_d;
            ctrl_q  <= ctrl_d;
            rdbuf_q <= rdbuf_d;
            wbuf_q  <= wbuf_d;
            state_q <= state_d;
        end
    end

    // Read data drive window
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            host_bus_out <= 8'h00;
            host_bus_oe  <= 1'b0;
        end else if (strobe_fall && new_read) begin
            host_bus_out <= out_d;
            host_bus_oe  <= 1'b1;
        end else if (strobe_rise) begin
            host_bus_oe  <= 1'b0;
        end
    end

    // Half-rate clock, phase fixed by reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            half_rate_clock <= 1'b0;
        end else begin
            half_rate_clock <= ~half_rate_clock;
        end
    end

    // Pixel path: delay line plus registered lookup gives the full latency
    logic [7:0] pixel_delayed;
    logic       bypass;

    assign bypass = ctrl_q[host_port_pkg::CTRL_BYPASS_BIT];

    pixel_delay_line #(
        .WIDTH (8),
        .DEPTH (LATENCY - 1)
    ) u_delay (
        .ref_clk (ref_clk),
        .srst    (srst),
        .din     (pixel_input_port),
        .dout    (pixel_delayed)
    );

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            video_word <= '0;
        end else if (bypass) begin
            video_word <= {pixel_delayed, pixel_delayed, pixel_delayed};
        end else begin
            video_word <= table_mem[pixel_delayed];
        end
    end

endmodule // video_encoder_host_port_lut_access

`default_nettype wire

// [test/host_port_chk.sv]
// Assertion checker bound to the encoder host port top module
`timescale 1ns/1ps
`default_nettype none

module host_port_chk #(
    parameter int ENTRIES = 256,
    parameter int LATENCY = host_port_pkg::PIXEL_PIPELINE_LATENCY
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Host port
    input wire logic        strobe_n,
    input wire logic        read_not_write,
    input wire logic [1:0]  port_select,
    input wire logic [7:0]  host_bus_in,
    input wire logic [7:0]  host_bus_out,
    input wire logic        host_bus_oe,
    // Pixel path
    input wire logic [7:0]  pixel_input_port,
    input wire logic [23:0] video_word,
    input wire logic        half_rate_clock
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_reset_state: assert property (
        $fell(srst) |-> !host_bus_oe && !half_rate_clock && video_word == 24'h0)
        else $error("outputs not idle after reset");
    a_half_toggle: assert property (
        !$past(srst) |-> half_rate_clock != $past(half_rate_clock))
        else $error("half rate clock missed a toggle");
    a_read_drive: assert property (
        $fell(strobe_n) && read_not_write ##1 !strobe_n[*2] |-> ##[1:12] host_bus_oe)
        else $error("read data not driven in time");
    a_oe_only_read: assert property (
        $rose(host_bus_oe) |-> read_not_write)
        else $error("bus driven on a write step");
    a_oe_release: assert property (
        $rose(strobe_n) |-> ##[1:6] !host_bus_oe)
        else $error("bus not released after strobe rise");
    a_bus_stable: assert property (
        host_bus_oe && $past(host_bus_oe) |-> $stable(host_bus_out))
        else $error("read data changed while driven");
    a_write_quiet: assert property (
        $fell(strobe_n) && !read_not_write ##1 !strobe_n[*5] |-> !host_bus_oe)
        else $error("bus driven during write step");
    a_spare_zero: assert property (
        $fell(strobe_n) && read_not_write && port_select == host_port_pkg::SEL_SPARE
        |-> ##[1:8] host_bus_oe && host_bus_out == 8'h00) else $error("spare read not zero");
    a_idle_quiet: assert property (
        strobe_n[*8] |-> !host_bus_oe)
        else $error("bus driven with no strobe pulse");
endmodule // host_port_chk

bind video_encoder_host_port_lut_access host_port_chk #(
    .ENTRIES(ENTRIES),
    .LATENCY(LATENCY)
) u_host_port_chk (
    .ref_clk(ref_clk), .srst(srst), .strobe_n(strobe_n),
    .read_not_write(read_not_write), .port_select(port_select),
    .host_bus_in(host_bus_in), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
    .pixel_input_port(pixel_input_port), .video_word(video_word),
    .half_rate_clock(half_rate_clock)
);

`default_nettype wire

// [test/host_cpu_model.sv]
// Behavioural host processor running strobed access steps
`timescale 1ns/1ps
`default_nettype none

module host_cpu_model (
    // Clock
    input  wire logic       ref_clk,
    // Host port
    output logic            strobe_n,
    output logic            read_not_write,
    output logic [1:0]      port_select,
    output logic [7:0]      host_bus_in,
    input  wire logic [7:0] host_bus_out,
    input  wire logic       host_bus_oe
);
    initial begin
        strobe_n = 1'b1;
        read_not_write = 1'b1;
        port_select = 2'h0;
        host_bus_in = 8'h5a;
    end

    // One fall and one rise per step; controls held past both edges
    task automatic step(input logic rw, input logic [1:0] sel, input logic [7:0] d,
                        input int low, output logic [7:0] q, output logic oe);
        @(negedge ref_clk);
        read_not_write = rw;
        port_select = sel;
        host_bus_in = ~host_bus_in;
        strobe_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        host_bus_in = rw ? ~host_bus_in : d; // Data valid only towards the rise
        repeat (low - 4) @(negedge ref_clk);
        // Not sampled before the read access delay; a released bus reads as noise
        q = host_bus_oe ? host_bus_out : ~host_bus_out;
        oe = host_bus_oe;
        strobe_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        host_bus_in = ~host_bus_in;
    endtask
endmodule // host_cpu_model

`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the encoder host port
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int LAT = host_port_pkg::PIXEL_PIPELINE_LATENCY;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        strobe_n;
    logic        read_not_write;
    logic [1:0]  port_select;
    logic [7:0]  host_bus_in;
    logic [7:0]  host_bus_out;
    logic        host_bus_oe;
    logic [7:0]  pixel_input_port = 8'h00;
    logic [23:0] video_word;
    logic        half_rate_clock;
    logic [7:0]  q;
    logic        oe;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          n = 0;
    // {check, rw, select, data, expected}; dummy reads and ending falls included
    logic [19:0] rows [27] = '{20'h10000, 20'h31100, 20'h32200, 20'h33300, 20'h34400,
        20'h35500, 20'h36600, 20'hd0002, 20'h10000, 20'h70000, 20'hf0011, 20'hf0022,
        20'hf0033, 20'hf0044, 20'h10100, 20'h37700, 20'h38800, 20'h39900, 20'hc0000,
        20'h10100, 20'h70000, 20'hf0077, 20'hf0088, 20'hc0000, 20'h70000, 20'hf0077,
        20'he0000};

    always #2 ref_clk = ~ref_clk;

    video_encoder_host_port_lut_access #(.LATENCY(LAT)) u_video_encoder_host_port_lut_access (
        .ref_clk(ref_clk), .srst(srst), .strobe_n(strobe_n),
        .read_not_write(read_not_write), .port_select(port_select),
        .host_bus_in(host_bus_in), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
        .pixel_input_port(pixel_input_port), .video_word(video_word),
        .half_rate_clock(half_rate_clock)
    );

    host_cpu_model u_host_cpu_model (
        .ref_clk(ref_clk), .strobe_n(strobe_n), .read_not_write(read_not_write),
        .port_select(port_select), .host_bus_in(host_bus_in),
        .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe)
    );

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        check_word({16'h0, got}, {16'h0, exp});
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        check_byte({7'h0, half_rate_clock}, 8'h00);
        @(negedge ref_clk);
        check_byte({7'h0, half_rate_clock}, 8'h01);
        @(negedge ref_clk);
        check_byte({7'h0, half_rate_clock}, 8'h00);
        // Alternate prompt and slow hosts
        foreach (rows[i]) begin
            u_host_cpu_model.step(rows[i][18], rows[i][17:16], rows[i][15:8],
                                  (i % 2) ? 15 : 24, q, oe);
            check_byte({7'h0, oe}, {7'h0, rows[i][18]});
            if (rows[i][19]) begin
                check_byte(q, rows[i][7:0]);
            end
        end
        check_word(video_word, 24'h112233);
        pixel_input_port = 8'h01;
        while (video_word !== 24'h778899 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        check_word(24'(n), 24'(LAT));
        // Bypass write stays pending until the next strobe fall
        u_host_cpu_model.step(1'b0, host_port_pkg::SEL_CONTROL, 8'h01, 15, q, oe);
        repeat (60) @(negedge ref_clk);
        check_word(video_word, 24'h778899);
        u_host_cpu_model.step(1'b1, host_port_pkg::SEL_CONTROL, 8'h00, 15, q, oe);
        check_byte(q, 8'h01);
        repeat (60) @(negedge ref_clk);
        check_word(video_word, 24'h010101);
        // A partial entry cut by a read restarts at the first component byte
        u_host_cpu_model.step(1'b0, host_port_pkg::SEL_ADDRESS, 8'h05, 24, q, oe);
        u_host_cpu_model.step(1'b0, host_port_pkg::SEL_TABLE, 8'haa, 15, q, oe);
        u_host_cpu_model.step(1'b1, host_port_pkg::SEL_ADDRESS, 8'h00, 15, q, oe);
        check_byte(q, 8'h05);
        u_host_cpu_model.step(1'b0, host_port_pkg::SEL_TABLE, 8'h01, 15, q, oe);
        u_host_cpu_model.step(1'b0, host_port_pkg::SEL_TABLE, 8'h02, 15, q, oe);
        u_host_cpu_model.step(1'b0, host_port_pkg::SEL_TABLE, 8'h03, 15, q, oe);
        u_host_cpu_model.step(1'b0, host_port_pkg::SEL_ADDRESS, 8'h05, 15, q, oe);
        u_host_cpu_model.step(1'b1, host_port_pkg::SEL_TABLE, 8'h00, 15, q, oe);
        u_host_cpu_model.step(1'b1, host_port_pkg::SEL_TABLE, 8'h00, 15, q, oe);
        check_byte(q, 8'h01);
        u_host_cpu_model.step(1'b1, host_port_pkg::SEL_TABLE, 8'h00, 24, q, oe);
        check_byte(q, 8'h02);
        // Spare select writes leave the control register alone
        u_host_cpu_model.step(1'b0, host_port_pkg::SEL_SPARE, 8'hff, 15, q, oe);
        u_host_cpu_model.step(1'b1, host_port_pkg::SEL_CONTROL, 8'h00, 15, q, oe);
        check_byte(q, 8'h01);
        // Reset in mid-run: outputs clear and the half-rate phase restarts
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        check_word(video_word, 24'h000000);
        check_byte({7'h0, half_rate_clock}, 8'h00);
        @(negedge ref_clk);
        check_byte({7'h0, half_rate_clock}, 8'h01);
        check_word(video_word, 24'h112233);
        u_host_cpu_model.step(1'b1, host_port_pkg::SEL_ADDRESS, 8'h00, 15, q, oe);
        check_byte(q, 8'h00);
        summarize();
    end
endmodule // testbench

`default_nettype wire
